// *** hw/sensor_output_conditioning.sv ***
// Purpose: output conditioning of a programmable field sensor
// Assumes: command decoder upstream delivers decoded strobes
// Notes: nonvolatile image is presented on nv ports and restored at reset
//
// Contract
// - Add quiescent offset to gained sample; zero sample gives offset.
// - Negative offset caps output at offset plus full supply.
// - Lower limit zero to half supply; output never below it, except lim_hi_q when lim_hi_q is lower and result exceeds it.
// - Upper limit zero to full supply; output never above it, except lim_lo_q when lim_lo_q is higher and result is below it.
// - Permanent lock freezes registers, ignores commands, never clears; reset clears lock_q, set again by nv_lock_i high at load or a lock command.
// - Lock command comes last; afterwards no write or read answered.
// - Readable 14-bit raw sample before any processing.
// - Calibration registers rewritable any number of times until locked.
// - Commit command stores values in non-volatile storage; code only pulses nv_store_o, no register values leave the block.
// - Output is sample times gain plus offset, then limited.
// - Gain one adds half supply per 2048 sample counts.
// - During command exchange, conditioned output off, digital answer on.
`timescale 1ns/1ns
`include "cond_map.svh"
module sensor_output_conditioning
  import cond_pkg::*;
#(
  parameter int SW = `SAMPLE_W
) (
  input wire logic clk_i, // Clock 100 MHz
  input wire logic rstn_i, // Async reset, low
  input wire logic sample_vld_i, // New filtered sample
  input wire logic signed [SW-1:0] sample_i, // Filtered sample
  input wire logic cmd_start_i, // Command exchange begins
  input wire logic cmd_wr_i, // Write strobe
  input wire logic cmd_rd_i, // Read strobe
  input wire logic cmd_lock_i, // Lock command
  input wire logic cmd_commit_i, // Commit-write command
  input wire cond_pkg::reg_sel_t cmd_sel_i, // Target register
  input wire logic [15:0] cmd_data_i, // Write data
  input wire logic nv_lock_i, // Stored lock bit
  input wire logic [`GAIN_W-1:0] nv_gain_i, // Stored gain
  input wire logic [`OFFS_W-1:0] nv_offs_i, // Stored offset
  input wire logic [`LIM_W-1:0] nv_lim_lo_i, // Stored lower limit
  input wire logic [`LIM_W-1:0] nv_lim_hi_i, // Stored upper limit
  input wire logic nv_load_i, // Stored image valid
  output logic [`OUT_W-1:0] out_code_o, // Code to converter
  output logic out_en_o, // Analog output enable
  output logic [15:0] ans_data_o, // Digital answer data
  output logic ans_vld_o, // Answer valid pulse
  output logic nv_store_o, // Commit pulse to storage
  output logic locked_o // Lock status
);
  logic [`GAIN_W-1:0] gain_q;
  logic [`OFFS_W-1:0] offs_q;
  logic [`LIM_W-1:0] lim_lo_q;
  logic [`LIM_W-1:0] lim_hi_q;
  logic lock_q;
  logic [SW-1:0] raw_q;
  logic loaded_q;
  cmd_state_t state_q, state_d;
  logic [`OUT_W-1:0] dp_code;
  logic dp_done;
  logic [15:0] rd_mux;
  logic live;
  logic wr_ok;
  logic load_now;

  // ----------------------------------------
  // Command gating
  // ----------------------------------------
  assign live = !lock_q;
  assign wr_ok = live && cmd_wr_i && state_q == ST_CMD;
  assign load_now = nv_load_i && !loaded_q;

  assign rd_mux = (cmd_sel_i == `SEL_GAIN) ? 16'(gain_q) :
                  (cmd_sel_i == `SEL_OFFS) ? 16'(offs_q) :
                  (cmd_sel_i == `SEL_LIMLO) ? 16'(lim_lo_q) :
                  (cmd_sel_i == `SEL_LIMHI) ? 16'(lim_hi_q) :
                  (cmd_sel_i == `SEL_LOCK) ? 16'(lock_q) :
                  (cmd_sel_i == `SEL_SAMPLE) ? 16'(raw_q) : 16'h0000;

  // ----------------------------------------
  // Exchange state machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: if (live && cmd_start_i) state_d = ST_CMD;
      ST_CMD: begin
        if (!live) state_d = ST_RUN;
        else if (cmd_rd_i || cmd_wr_i || cmd_commit_i || cmd_lock_i) state_d = ST_ANS;
      end
      ST_ANS: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_RUN;
      ans_vld_o <= 1'b0;
      ans_data_o <= 16'h0000;
      out_en_o <= 1'b0;
      nv_store_o <= 1'b0;
    end else begin
      state_q <= state_d;
      out_en_o <= (state_d == ST_RUN);
      ans_vld_o <= live && state_q == ST_CMD && cmd_rd_i;
      if (live && state_q == ST_CMD && cmd_rd_i) ans_data_o <= rd_mux;
      nv_store_o <= live && state_q == ST_CMD && cmd_commit_i;
    end
  end

  // ----------------------------------------
  // Calibration registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gain_q <= `GAIN_RST;
      offs_q <= `OFFS_RST;
      lim_lo_q <= `LIMLO_RST;
      lim_hi_q <= `LIMHI_RST;
      loaded_q <= 1'b0;
    end else if (load_now) begin
      loaded_q <= 1'b1;
      gain_q <= nv_gain_i;
      offs_q <= nv_offs_i;
      lim_lo_q <= (nv_lim_lo_i > `LIMLO_MAX) ? `LIMLO_MAX : nv_lim_lo_i;
      lim_hi_q <= nv_lim_hi_i;
    end else if (wr_ok) begin
      if (cmd_sel_i == `SEL_GAIN) gain_q <= cmd_data_i[`GAIN_W-1:0];
      if (cmd_sel_i == `SEL_OFFS) offs_q <= cmd_data_i[`OFFS_W-1:0];
      if (cmd_sel_i == `SEL_LIMLO) begin
        lim_lo_q <= (cmd_data_i[`LIM_W-1:0] > `LIMLO_MAX) ? `LIMLO_MAX
                    : cmd_data_i[`LIM_W-1:0];
      end
      if (cmd_sel_i == `SEL_LIMHI) lim_hi_q <= cmd_data_i[`LIM_W-1:0];
    end
  end

  // ----------------------------------------
  // Permanent lock, set only
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      if ((load_now && nv_lock_i) || (live && state_q == ST_CMD && cmd_lock_i)) begin
        lock_q <= 1'b1;
      end
      locked_o <= lock_q;
    end
  end

  // ----------------------------------------
  // Raw sample capture and datapath
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_q <= '0;
      out_code_o <= '0;
    end else begin
      if (sample_vld_i) raw_q <= sample_i;
      if (dp_done) out_code_o <= dp_code;
    end
  end

  cond_datapath #(.SW(SW)) u_dp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(sample_vld_i),
    .sample_i(sample_i),
    .gain_i($signed(gain_q)),
    .offs_i($signed(offs_q)),
    .lim_lo_i(lim_lo_q),
    .lim_hi_i(lim_hi_q),
    .code_o(dp_code),
    .done_o(dp_done)
  );
endmodule

// *** hw/cond_map.svh ***
// Purpose: constants for the output conditioning stage
// Assumes: 12-bit output code spans 0..supply
// Notes: step sizes follow the 5 V scaling
`ifndef COND_MAP_SVH
`define COND_MAP_SVH
`define SAMPLE_W 14
`define OUT_W 12
`define GAIN_W 14
`define GAIN_FRAC 11
`define OFFS_W 13
`define LIM_W 12
`define LIMLO_MAX 12'h7ff
`define OUT_FULL 13'sh0fff
`define GAIN_RST 14'h0800
`define OFFS_RST 13'h0800
`define LIMLO_RST 12'h000
`define LIMHI_RST 12'hfff
`define SEL_GAIN 3'h0
`define SEL_OFFS 3'h1
`define SEL_LIMLO 3'h2
`define SEL_LIMHI 3'h3
`define SEL_LOCK 3'h4
`define SEL_SAMPLE 3'h5
`endif

// *** hw/cond_pkg.sv ***
// Purpose: shared types for the output conditioning stage
// Assumes: nothing
// Notes: selector type for programming commands
package cond_pkg;
  typedef logic [2:0] reg_sel_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_CMD = 3'b010,
    ST_ANS = 3'b100
  } cmd_state_t;
endpackage

// *** hw/cond_datapath.sv ***
// Purpose: gain, offset and limit arithmetic on one sample
// Assumes: gain is signed with GAIN_FRAC fraction bits
// Notes: registered result, one cycle latency
`timescale 1ns/1ns
`include "cond_map.svh"
module cond_datapath #(
  parameter int SW = `SAMPLE_W
) (
  input wire logic clk_i, // Clock
  input wire logic rstn_i, // Async reset, low
  input wire logic en_i, // New sample strobe
  input wire logic signed [SW-1:0] sample_i, // Raw sample
  input wire logic signed [`GAIN_W-1:0] gain_i, // Gain
  input wire logic signed [`OFFS_W-1:0] offs_i, // Offset code
  input wire logic [`LIM_W-1:0] lim_lo_i, // Lower limit
  input wire logic [`LIM_W-1:0] lim_hi_i, // Upper limit
  output logic [`OUT_W-1:0] code_o, // Conditioned code
  output logic done_o // Result valid pulse
);
  logic signed [SW+`GAIN_W-1:0] prod;
  logic signed [SW+`GAIN_W-1:0] scaled;
  logic signed [SW+`GAIN_W-1:0] sum;
  logic signed [SW+`GAIN_W-1:0] top;
  logic signed [SW+`GAIN_W-1:0] capped;
  logic signed [SW+`GAIN_W-1:0] lo_s;
  logic signed [SW+`GAIN_W-1:0] hi_s;
  logic [`OUT_W-1:0] code_d;
  assign prod = sample_i * gain_i;
  assign scaled = prod >>> `GAIN_FRAC;
  assign sum = scaled + (SW+`GAIN_W)'(offs_i);
  // Negative offset lowers reachable ceiling
  assign top = (offs_i < 0) ? (SW+`GAIN_W)'(offs_i) + (SW+`GAIN_W)'(`OUT_FULL)
                            : (SW+`GAIN_W)'(`OUT_FULL);
  assign capped = (sum > top) ? top : sum;
  assign lo_s = (SW+`GAIN_W)'($signed({1'b0, lim_lo_i}));
  assign hi_s = (SW+`GAIN_W)'($signed({1'b0, lim_hi_i}));
  assign code_d = (capped < lo_s) ? lim_lo_i :
                  (capped > hi_s) ? lim_hi_i :
                  (capped < 0) ? '0 : capped[`OUT_W-1:0];
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= en_i;
      if (en_i) code_o <= code_d;
    end
  end
endmodule

// *** dv/soc_assertions.sv ***
// Purpose: port checks of the conditioning stage
// Assumes: one clock, reset low
// Notes: bound below
`timescale 1ns/1ns
module soc_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sample_vld_i,
  input wire logic cmd_start_i,
  input wire logic cmd_rd_i,
  input wire logic cmd_commit_i,
  input wire logic [11:0] out_code_o,
  input wire logic out_en_o,
  input wire logic ans_vld_o,
  input wire logic nv_store_o,
  input wire logic locked_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_go; !locked_o && out_en_o && cmd_start_i; endsequence
  property p_rd; s_go ##1 cmd_rd_i |=> ans_vld_o; endproperty
  a_rd: assert property (p_rd) else $error("no answer");
  property p_cm; s_go ##1 cmd_commit_i |=> nv_store_o; endproperty
  a_cm: assert property (p_cm) else $error("no store");
  property p_st; nv_store_o |-> $past(cmd_commit_i) && !$past(locked_o); endproperty
  a_st: assert property (p_st) else $error("stray store");
  property p_an; ans_vld_o |-> $past(cmd_rd_i) && !$past(locked_o); endproperty
  a_an: assert property (p_an) else $error("stray answer");
  property p_off; s_go |=> !out_en_o; endproperty
  a_off: assert property (p_off) else $error("output on");
  property p_bk; $fell(out_en_o) |-> ##[1:4] out_en_o; endproperty
  a_bk: assert property (p_bk) else $error("output stuck off");
  property p_lk; locked_o |=> locked_o; endproperty
  a_lk: assert property (p_lk) else $error("lock cleared");
  property p_lz; locked_o [*4] |-> out_en_o && !ans_vld_o; endproperty
  a_lz: assert property (p_lz) else $error("locked but busy");
  property p_hd; $changed(out_code_o) |-> $past(sample_vld_i, 2); endproperty
  a_hd: assert property (p_hd) else $error("code moved");
endmodule
bind sensor_output_conditioning soc_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .sample_vld_i(sample_vld_i), .cmd_start_i(cmd_start_i), .cmd_rd_i(cmd_rd_i),
  .cmd_commit_i(cmd_commit_i), .out_code_o(out_code_o), .out_en_o(out_en_o),
  .ans_vld_o(ans_vld_o), .nv_store_o(nv_store_o), .locked_o(locked_o));

// *** dv/prog_tool.sv ***
// Purpose: programming tool model
// Assumes: decoded command strobes
// Notes: counts answers
`timescale 1ns/1ns
module prog_tool (
  input wire logic clk_i, // Clock
  input wire logic ans_vld_i, // Answer
  input wire logic [15:0] ans_data_i, // Answer data
  output logic st_o, // Start
  output logic [3:0] stb_o, // Lock,commit,rd,wr
  output logic [2:0] sel_o, // Register
  output logic [15:0] dat_o // Data
);
  int n_ans = 0;
  logic [15:0] rd_q = 16'h0000;
  initial begin
    st_o = 1'b0;
    stb_o = 4'h0;
    sel_o = 3'h0;
    dat_o = 16'h0000;
  end
  always @(posedge clk_i) begin
    if (ans_vld_i) begin
      n_ans <= n_ans + 1;
      rd_q <= ans_data_i;
    end
  end
  task automatic op(input int k, input logic [2:0] s, input logic [15:0] d);
    @(negedge clk_i);
    st_o = 1'b1;
    sel_o = s;
    dat_o = d;
    @(negedge clk_i);
    st_o = 1'b0;
    stb_o = 4'h1 << k;
    @(negedge clk_i);
    stb_o = 4'h0;
    repeat (3) @(negedge clk_i);
  endtask
endmodule

// *** dv/test_sensor_output_conditioning.sv ***
// Purpose: self-checking bench of the conditioning stage
// Assumes: tool model issues commands
// Notes: gain one gives half scale per 2048
`timescale 1ns/1ns
`include "cond_map.svh"
module test_sensor_output_conditioning;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic vld = 1'b0;
  logic [13:0] smp = 14'h0000;
  logic nv_lock = 1'b0;
  logic [11:0] code;
  logic en, ans_vld, store, locked, st;
  logic [15:0] ans, dat;
  logic [3:0] stb;
  logic [2:0] sel;
  int fail_count = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  prog_tool tool (.clk_i(clk_i), .ans_vld_i(ans_vld), .ans_data_i(ans), .st_o(st),
    .stb_o(stb), .sel_o(sel), .dat_o(dat));
  sensor_output_conditioning dut (.clk_i(clk_i), .rstn_i(rstn_i), .sample_vld_i(vld),
    .sample_i(smp), .cmd_start_i(st), .cmd_wr_i(stb[0]), .cmd_rd_i(stb[1]),
    .cmd_commit_i(stb[2]), .cmd_lock_i(stb[3]), .cmd_sel_i(sel), .cmd_data_i(dat),
    .nv_lock_i(nv_lock), .nv_gain_i(14'h0800), .nv_offs_i(13'h0000),
    .nv_lim_lo_i(12'h000), .nv_lim_hi_i(12'hfff), .nv_load_i(1'b1), .out_code_o(code),
    .out_en_o(en), .ans_data_o(ans), .ans_vld_o(ans_vld), .nv_store_o(store),
    .locked_o(locked));
  function automatic logic [11:0] f(int s, int g, int o, int lo, int hi);
    int v;
    v = ((s * g) >>> `GAIN_FRAC) + o;
    if (v > ((o < 0) ? o + 4095 : 4095)) v = (o < 0) ? o + 4095 : 4095;
    if (v < lo) v = lo;
    if (v > hi) v = hi;
    return (v < 0) ? 12'h000 : v[11:0];
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic sc(input int s, input logic [11:0] e);
    @(negedge clk_i);
    smp = s[13:0];
    vld = 1'b1;
    @(negedge clk_i);
    vld = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({4'h0, code}, {4'h0, e});
  endtask
  task automatic rst();
    rstn_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int n;
    rst();
    tool.op(0, `SEL_LIMLO, 16'h0000);
    tool.op(0, `SEL_LIMHI, 16'h0fff);
    tool.op(0, `SEL_GAIN, 16'h0400);
    tool.op(0, `SEL_GAIN, 16'h0800);
    tool.op(0, `SEL_OFFS, 16'h0100);
    sc(0, 12'h100);
    sc(1000, f(1000, 2048, 256, 0, 4095));
    sc(3000, 12'hcb8);
    sc(-200, 12'h038);
    $display("calibration done");
    tool.op(0, `SEL_GAIN, 16'h1fff);
    tool.op(0, `SEL_OFFS, 16'h1c18);
    sc(8191, f(8191, 8191, -1000, 0, 4095));
    $display("negative offset done");
    tool.op(0, `SEL_GAIN, 16'h0800);
    tool.op(0, `SEL_OFFS, 16'h0800);
    tool.op(0, `SEL_LIMLO, 16'h0200);
    tool.op(0, `SEL_LIMHI, 16'h0a00);
    tool.op(2, `SEL_GAIN, 16'h0000);
    sc(2000, 12'ha00);
    sc(0, 12'h800);
    sc(-2000, 12'h200);
    sc(-1234, 12'h32e);
    $display("limits done");
    n = tool.n_ans;
    tool.op(1, `SEL_SAMPLE, 16'h0000);
    chk(16'(tool.n_ans - n), 16'h0001);
    chk({2'h0, tool.rd_q[13:0]}, 16'h3b2e);
    $display("readout done");
    tool.op(3, `SEL_LOCK, 16'h0001);
    chk({15'h0, locked}, 16'h0001);
    n = tool.n_ans;
    tool.op(1, `SEL_SAMPLE, 16'h0000);
    tool.op(0, `SEL_OFFS, 16'h0000);
    chk(16'(tool.n_ans - n), 16'h0000);
    sc(0, 12'h800);
    nv_lock = 1'b1;
    rst();
    chk({15'h0, locked}, 16'h0001);
    $display("lock done");
    complete_run();
  end
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule
